// *** rtl/mcc_pkg.sv ***
package mcc_pkg;

    // ======================================================================
    // register map (printed offsets are indices; byte address is index * 4)
    // ======================================================================
    localparam logic [7:0] IDX_CLOCK_CONTROL_STATUS = 8'h2C;
    localparam logic [7:0] IDX_BEEP_CONTROL = 8'h2D;
    localparam int IDX_SHIFT = 2;
    localparam int BUS_DATA_W = 32;
    localparam int REG_W = 8;

    // ======================================================================
    // clock_control_status_reg fields
    // ======================================================================
    localparam int BIT_CLOCK_OUT_ENABLE = 7;
    localparam int BIT_PRESCALE_HI = 6;
    localparam int BIT_PRESCALE_LO = 5;
    localparam int BIT_SLOW_SELECT = 4;
    localparam int BIT_TIME_BASE_HI = 3;
    localparam int BIT_TIME_BASE_LO = 2;
    localparam int BIT_TICK_IRQ_ENABLE = 1;
    localparam int BIT_TICK_IRQ_FLAG = 0;
    localparam int BEEP_SEL_W = 2;

    // ======================================================================
    // reset values
    // ======================================================================
    localparam logic [7:0] CLOCK_CONTROL_STATUS_RESET = 8'h00;
    localparam logic [7:0] BEEP_CONTROL_RESET = 8'h00;

    // ======================================================================
    // time-base dividers of osc_clock, per time_base_sel code
    // ======================================================================
    localparam int TB_DIV_0 = 16000;
    localparam int TB_DIV_1 = 32000;
    localparam int TB_DIV_2 = 80000;
    localparam int TB_DIV_3 = 200000;

    // ======================================================================
    // beep tones, defined at the reference oscillator rate
    // ======================================================================
    localparam int BEEP_REF_OSC_HZ = 8000000;
    localparam int BEEP_HZ_1 = 2000;
    localparam int BEEP_HZ_2 = 1000;
    localparam int BEEP_HZ_3 = 500;
    localparam int BEEP_HALF_1 = BEEP_REF_OSC_HZ / (2 * BEEP_HZ_1);
    localparam int BEEP_HALF_2 = BEEP_REF_OSC_HZ / (2 * BEEP_HZ_2);
    localparam int BEEP_HALF_3 = BEEP_REF_OSC_HZ / (2 * BEEP_HZ_3);

    // ======================================================================
    // power modes and bus responses
    // ======================================================================
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_ACTIVE_HALT = 2'b01,
        PM_HALT = 2'b10
    } pmode_t;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** rtl/tick_if.sv ***
`timescale 1ns/1ps
// time-base request from the controller and tick back from the generator
interface tick_if;
    logic [1:0] tb_sel;
    logic run;
    logic tick;

    modport ctl (output tb_sel, output run, input tick);
    modport gen (input tb_sel, input run, output tick);
endinterface

// *** rtl/tick_gen.sv ***
`timescale 1ns/1ps
module tick_gen #(
    parameter int TB_DIV_0 = mcc_pkg::TB_DIV_0,
    parameter int TB_DIV_1 = mcc_pkg::TB_DIV_1,
    parameter int TB_DIV_2 = mcc_pkg::TB_DIV_2,
    parameter int TB_DIV_3 = mcc_pkg::TB_DIV_3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // controller side
    tick_if.gen tk
);

    localparam int CNT_W = $clog2(TB_DIV_3 + 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [1:0] act_sel;
        logic tick;
    } tick_state_t;

    tick_state_t st_ff;
    tick_state_t nxt_st;

    // last count of the period for a time-base code
    function automatic logic [CNT_W-1:0] period_last(input logic [1:0] sel);
        logic [CNT_W-1:0] res;
        res = CNT_W'(TB_DIV_0 - 1);
        unique case (sel)
            2'b00: res = CNT_W'(TB_DIV_0 - 1);
            2'b01: res = CNT_W'(TB_DIV_1 - 1);
            2'b10: res = CNT_W'(TB_DIV_2 - 1);
            2'b11: res = CNT_W'(TB_DIV_3 - 1);
        endcase
        return res;
    endfunction

    assign tk.tick = st_ff.tick;

    // counter advances on every osc_clock edge except in full halt
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (tk.run) begin
            if (st_ff.cnt >= period_last(st_ff.act_sel)) begin
                nxt_st.cnt = '0;
                nxt_st.tick = 1'b1;
                nxt_st.act_sel = tk.tb_sel;
            end else begin
                nxt_st.cnt = st_ff.cnt + CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// *** rtl/main_clock_rtc_beeper.sv ***
`timescale 1ns/1ps
module main_clock_rtc_beeper #(
    parameter int ADDR_W = 12,
    parameter int TB_DIV_0 = mcc_pkg::TB_DIV_0,
    parameter int TB_DIV_1 = mcc_pkg::TB_DIV_1,
    parameter int TB_DIV_2 = mcc_pkg::TB_DIV_2,
    parameter int TB_DIV_3 = mcc_pkg::TB_DIV_3,
    parameter int BEEP_HALF_1 = mcc_pkg::BEEP_HALF_1,
    parameter int BEEP_HALF_2 = mcc_pkg::BEEP_HALF_2,
    parameter int BEEP_HALF_3 = mcc_pkg::BEEP_HALF_3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // cpu core
    input wire logic halt_instr_in,
    input wire logic irq_mask_in,
    input wire logic halt_wake_in,
    output logic cpu_clk_en_out,
    output logic tick_irq_out,
    output logic [1:0] power_mode_out,
    // pins
    output logic clock_out_pin_out,
    output logic clock_out_oe_out,
    output logic beep_pin_out,
    output logic beep_oe_out
);

    // ======================================================================
    // types and state
    // ======================================================================
    localparam int BEEP_W = $clog2(BEEP_HALF_3 + 1);
    localparam int DIV_W = 5;
    localparam int PAD_W = mcc_pkg::BUS_DATA_W - mcc_pkg::REG_W;

    typedef struct packed {
        mcc_pkg::pmode_t pm;
        logic [mcc_pkg::REG_W-1:0] ccs;
        logic [mcc_pkg::BEEP_SEL_W-1:0] beep_sel;
        logic aw_free;
        logic [ADDR_W-1:0] aw_addr;
        logic w_free;
        logic [mcc_pkg::REG_W-1:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_free;
        logic rvalid;
        logic [mcc_pkg::REG_W-1:0] rdata;
        logic [1:0] rresp;
        logic [DIV_W-1:0] div_cnt;
        logic cpu_en;
        logic clk_out;
        logic clk_oe;
        logic [BEEP_W-1:0] beep_cnt;
        logic beep;
        logic beep_oe;
        logic irq;
    } mcc_state_t;

    mcc_state_t st_ff;
    mcc_state_t nxt_st;

    tick_if tk ();

    // ======================================================================
    // functions
    // ======================================================================
    // byte address match for a register index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr == ADDR_W'({idx, {mcc_pkg::IDX_SHIFT{1'b0}}});
    endfunction

    // cpu clock ratio from slow_select and cpu_prescale_sel
    function automatic logic [DIV_W-1:0] cpu_ratio(input logic slow, input logic [1:0] pre);
        logic [DIV_W-1:0] res;
        res = DIV_W'(1);
        if (slow) begin
            res = DIV_W'(2) << pre;
        end
        return res;
    endfunction

    // half period of the beep tone; zero means off
    function automatic logic [BEEP_W-1:0] beep_half(input logic [1:0] sel);
        logic [BEEP_W-1:0] res;
        res = '0;
        unique case (sel)
            2'b00: res = '0;
            2'b01: res = BEEP_W'(BEEP_HALF_1);
            2'b10: res = BEEP_W'(BEEP_HALF_2);
            2'b11: res = BEEP_W'(BEEP_HALF_3);
        endcase
        return res;
    endfunction

    // ======================================================================
    // time-base generator
    // ======================================================================
    // counter stops only in full halt
    assign tk.run = (st_ff.pm != mcc_pkg::PM_HALT);
    assign tk.tb_sel = st_ff.ccs[mcc_pkg::BIT_TIME_BASE_HI:mcc_pkg::BIT_TIME_BASE_LO];

    tick_gen #(
        .TB_DIV_0(TB_DIV_0),
        .TB_DIV_1(TB_DIV_1),
        .TB_DIV_2(TB_DIV_2),
        .TB_DIV_3(TB_DIV_3)
    ) u_tick_gen (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tk(tk)
    );

    // ======================================================================
    // next-state logic
    // ======================================================================
    always_comb begin
        logic regs_live;
        logic rd_clear;
        logic tie;
        logic [DIV_W-1:0] ratio;
        logic [BEEP_W-1:0] half;
        regs_live = 1'b0;
        rd_clear = 1'b0;
        tie = 1'b0;
        ratio = '0;
        half = '0;
        nxt_st = st_ff;
        regs_live = (st_ff.pm == mcc_pkg::PM_RUN);
        tie = st_ff.ccs[mcc_pkg::BIT_TICK_IRQ_ENABLE];

        // write address and data are taken independently
        if (st_ff.aw_free && s_axi_awvalid_in) begin
            nxt_st.aw_free = 1'b0;
            nxt_st.aw_addr = s_axi_awaddr_in;
        end
        if (st_ff.w_free && s_axi_wvalid_in) begin
            nxt_st.w_free = 1'b0;
            nxt_st.w_data = s_axi_wdata_in[mcc_pkg::REG_W-1:0];
            nxt_st.w_lane = s_axi_wstrb_in[0];
        end

        // response retires before the next write is executed
        if (st_ff.bvalid && s_axi_bready_in) begin
            nxt_st.bvalid = 1'b0;
        end
        if (!st_ff.aw_free && !st_ff.w_free && !st_ff.bvalid) begin
            nxt_st.aw_free = 1'b1;
            nxt_st.w_free = 1'b1;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = mcc_pkg::RESP_OKAY;
            if (reg_hit(st_ff.aw_addr, mcc_pkg::IDX_CLOCK_CONTROL_STATUS)) begin
                // flag bit is not writable
                if (st_ff.w_lane && regs_live) begin
                    nxt_st.ccs[mcc_pkg::REG_W-1:1] = st_ff.w_data[mcc_pkg::REG_W-1:1];
                end
            end else if (reg_hit(st_ff.aw_addr, mcc_pkg::IDX_BEEP_CONTROL)) begin
                // upper bits dropped, read as zero
                if (st_ff.w_lane && regs_live) begin
                    nxt_st.beep_sel = st_ff.w_data[mcc_pkg::BEEP_SEL_W-1:0];
                end
            end else begin
                nxt_st.bresp = mcc_pkg::RESP_SLVERR;
            end
        end

        // read path: data captured at address handshake
        if (st_ff.rvalid && s_axi_rready_in) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.ar_free = 1'b1;
        end
        if (st_ff.ar_free && s_axi_arvalid_in) begin
            nxt_st.ar_free = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = mcc_pkg::RESP_OKAY;
            nxt_st.rdata = '0;
            if (reg_hit(s_axi_araddr_in, mcc_pkg::IDX_CLOCK_CONTROL_STATUS)) begin
                nxt_st.rdata = st_ff.ccs;
                rd_clear = regs_live;
            end else if (reg_hit(s_axi_araddr_in, mcc_pkg::IDX_BEEP_CONTROL)) begin
                nxt_st.rdata[mcc_pkg::BEEP_SEL_W-1:0] = st_ff.beep_sel;
            end else begin
                nxt_st.rresp = mcc_pkg::RESP_SLVERR;
            end
        end

        // set by tick, cleared by read in run mode only, set wins
        nxt_st.ccs[mcc_pkg::BIT_TICK_IRQ_FLAG] =
            (st_ff.ccs[mcc_pkg::BIT_TICK_IRQ_FLAG] & ~rd_clear) | tk.tick;

        nxt_st.irq = nxt_st.ccs[mcc_pkg::BIT_TICK_IRQ_FLAG]
            & nxt_st.ccs[mcc_pkg::BIT_TICK_IRQ_ENABLE] & ~irq_mask_in;

        // power mode sequencing
        unique case (st_ff.pm)
            mcc_pkg::PM_RUN: begin
                if (halt_instr_in) begin
                    nxt_st.pm = tie ? mcc_pkg::PM_ACTIVE_HALT : mcc_pkg::PM_HALT;
                end
            end
            mcc_pkg::PM_ACTIVE_HALT: begin
                if ((st_ff.ccs[mcc_pkg::BIT_TICK_IRQ_FLAG] && tie) || halt_wake_in) begin
                    nxt_st.pm = mcc_pkg::PM_RUN;
                end
            end
            mcc_pkg::PM_HALT: begin
                if (halt_wake_in) begin
                    nxt_st.pm = mcc_pkg::PM_RUN;
                end
            end
            default: begin
                nxt_st.pm = mcc_pkg::PM_RUN;
            end
        endcase

        ratio = cpu_ratio(st_ff.ccs[mcc_pkg::BIT_SLOW_SELECT],
                          st_ff.ccs[mcc_pkg::BIT_PRESCALE_HI:mcc_pkg::BIT_PRESCALE_LO]);
        nxt_st.cpu_en = 1'b0;
        if (regs_live) begin
            if (st_ff.div_cnt >= ratio - DIV_W'(1)) begin
                nxt_st.div_cnt = '0;
                nxt_st.cpu_en = 1'b1;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + DIV_W'(1);
            end
        end

        // clock out on pin when enabled, in run mode only
        nxt_st.clk_oe = st_ff.ccs[mcc_pkg::BIT_CLOCK_OUT_ENABLE];
        if (!regs_live || !st_ff.ccs[mcc_pkg::BIT_CLOCK_OUT_ENABLE]) begin
            nxt_st.clk_out = 1'b0;
        end else if (ratio == DIV_W'(1)) begin
            nxt_st.clk_out = ~st_ff.clk_out;
        end else begin
            nxt_st.clk_out = nxt_st.div_cnt < (ratio >> 1);
        end

        half = beep_half(st_ff.beep_sel);
        nxt_st.beep_oe = (half != '0);
        if (half == '0) begin
            nxt_st.beep = 1'b0;
            nxt_st.beep_cnt = '0;
        end else if (st_ff.pm != mcc_pkg::PM_HALT) begin
            if (st_ff.beep_cnt >= half - BEEP_W'(1)) begin
                nxt_st.beep_cnt = '0;
                nxt_st.beep = ~st_ff.beep;
            end else begin
                nxt_st.beep_cnt = st_ff.beep_cnt + BEEP_W'(1);
            end
        end
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.ccs <= mcc_pkg::CLOCK_CONTROL_STATUS_RESET;
            st_ff.beep_sel <= mcc_pkg::BEEP_CONTROL_RESET[mcc_pkg::BEEP_SEL_W-1:0];
            st_ff.pm <= mcc_pkg::PM_RUN;
            st_ff.aw_free <= 1'b1;
            st_ff.w_free <= 1'b1;
            st_ff.ar_free <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    // bus channels
    assign s_axi_awready_out = st_ff.aw_free;
    assign s_axi_wready_out = st_ff.w_free;
    assign s_axi_bresp_out = st_ff.bresp;
    assign s_axi_bvalid_out = st_ff.bvalid;
    assign s_axi_arready_out = st_ff.ar_free;
    assign s_axi_rdata_out = {{PAD_W{1'b0}}, st_ff.rdata};
    assign s_axi_rresp_out = st_ff.rresp;
    assign s_axi_rvalid_out = st_ff.rvalid;

    // core and pins
    assign cpu_clk_en_out = st_ff.cpu_en;
    assign tick_irq_out = st_ff.irq;
    assign power_mode_out = st_ff.pm;
    assign clock_out_pin_out = st_ff.clk_out;
    assign clock_out_oe_out = st_ff.clk_oe;
    assign beep_pin_out = st_ff.beep;
    assign beep_oe_out = st_ff.beep_oe;

endmodule

// *** dv/main_clock_rtc_beeper_monitor.sv ***
`timescale 1ns/1ps
// ============
// clock controller port checker
module main_clock_rtc_beeper_monitor (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // core side
    input wire logic halt_instr_in,
    input wire logic irq_mask_in,
    input wire logic halt_wake_in,
    input wire logic cpu_clk_en_out,
    input wire logic tick_irq_out,
    input wire logic [1:0] power_mode_out,
    // pins and read data
    input wire logic clock_out_pin_out,
    input wire logic clock_out_oe_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [31:0] s_axi_rdata_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [4:0] gap_ff;

    // run cycles since last cpu strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || cpu_clk_en_out || power_mode_out != 2'h0) begin
            gap_ff <= 5'h00;
        end else begin
            gap_ff <= gap_ff + 5'h01;
        end
    end

    property p_irq_masked;
        tick_irq_out |-> !$past(irq_mask_in);
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("tick irq while masked");
    property p_halt_holds;
        power_mode_out == mcc_pkg::PM_HALT && !halt_wake_in |=> power_mode_out == mcc_pkg::PM_HALT;
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("halt left without wake");
    property p_halt_wake;
        power_mode_out == mcc_pkg::PM_HALT && halt_wake_in |=> power_mode_out == mcc_pkg::PM_RUN;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not left on wake");
    property p_halt_entry;
        power_mode_out == mcc_pkg::PM_RUN && halt_instr_in |=> power_mode_out inside {2'h1, 2'h2};
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt instruction ignored");
    property p_halt_no_clk;
        power_mode_out != 2'h0 && $past(power_mode_out) != 2'h0 |-> !cpu_clk_en_out;
    endproperty
    a_halt_no_clk: assert property (p_halt_no_clk) else $error("cpu clock in halt");
    property p_clkout_ahalt;
        power_mode_out == 2'h1 && $past(power_mode_out) == 2'h1 |-> !clock_out_pin_out;
    endproperty
    a_clkout_ahalt: assert property (p_clkout_ahalt) else $error("clock out in active halt");
    property p_clkout_free;
        !clock_out_oe_out && !$past(clock_out_oe_out) |-> !clock_out_pin_out;
    endproperty
    a_clkout_free: assert property (p_clkout_free) else $error("clock out while disabled");
    property p_slow_gap;
        gap_ff < 5'h10;
    endproperty
    a_slow_gap: assert property (p_slow_gap) else $error("cpu clock gap above 16");
    property p_rdata_hi;
        s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("read data above bit 7");
endmodule

bind main_clock_rtc_beeper main_clock_rtc_beeper_monitor mon_u (
    .clk_in, .rst_n_in, .halt_instr_in, .irq_mask_in, .halt_wake_in, .cpu_clk_en_out,
    .tick_irq_out, .power_mode_out, .clock_out_pin_out, .clock_out_oe_out,
    .s_axi_rvalid_out, .s_axi_rdata_out
);

// *** dv/cpu_core_model.sv ***
`timescale 1ns/1ps
// ============
// core model: bench requests to core signals
module cpu_core_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // requests from the bench
    input wire logic halt_req_in,
    input wire logic wake_req_in,
    input wire logic mask_req_in,
    // controller side
    input wire logic cpu_clk_en_in,
    output logic halt_instr_out,
    output logic halt_wake_out,
    output logic irq_mask_out,
    output logic [15:0] cpu_ticks_out
);
    // halt only on a cpu strobe
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            halt_instr_out <= 1'b0;
            halt_wake_out <= 1'b0;
            irq_mask_out <= 1'b0;
            cpu_ticks_out <= 16'h0000;
        end else begin
            halt_instr_out <= halt_req_in && cpu_clk_en_in;
            irq_mask_out <= mask_req_in;
            halt_wake_out <= wake_req_in;
            cpu_ticks_out <= cpu_ticks_out + {15'h0000, cpu_clk_en_in};
        end
    end
endmodule

// *** dv/main_clock_rtc_beeper_bench.sv ***
`timescale 1ns/1ps
// ============
// clock controller bench
module main_clock_rtc_beeper_bench;
    localparam logic [11:0] A_CSR = 12'h0B0;
    localparam logic [11:0] A_BEEP = 12'h0B4;
    localparam logic [11:0] A_BAD = 12'h0B8;
    localparam int TB_DIV [4] = '{16, 32, 80, 200};
    localparam int BEEP_HALF [4] = '{0, 4, 8, 16};
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, power_mode_out;
    logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, halt_instr_in, irq_mask_in, halt_wake_in, cpu_clk_en_out;
    logic tick_irq_out, clock_out_pin_out, clock_out_oe_out, beep_pin_out, beep_oe_out;
    logic halt_req, wake_req, mask_req;
    logic [15:0] cpu_ticks;
    int n_fail = 0, n_tests = 0, cyc = 0;
    int seed = 32'h637B;
    int exp_q [$];

    // clock and cycle count
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;

    main_clock_rtc_beeper #(.TB_DIV_0(16), .TB_DIV_1(32), .TB_DIV_2(80), .TB_DIV_3(200),
        .BEEP_HALF_1(4), .BEEP_HALF_2(8), .BEEP_HALF_3(16)) dut_u (
        .clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
        .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
        .s_axi_rvalid_out, .s_axi_rready_in, .halt_instr_in, .irq_mask_in, .halt_wake_in,
        .cpu_clk_en_out, .tick_irq_out, .power_mode_out, .clock_out_pin_out,
        .clock_out_oe_out, .beep_pin_out, .beep_oe_out);

    cpu_core_model core_u (.clk_in, .rst_n_in, .halt_req_in(halt_req), .wake_req_in(wake_req),
        .mask_req_in(mask_req), .cpu_clk_en_in(cpu_clk_en_out), .halt_instr_out(halt_instr_in),
        .halt_wake_out(halt_wake_in), .irq_mask_out(irq_mask_in), .cpu_ticks_out(cpu_ticks));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bus write: aw and w together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        r = s_axi_bresp_out;
    endtask

    // bus read
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
    endtask

    // waits for tick irq (0), cpu strobe (1) or beep edge (2)
    task automatic wait_hi(input int k, output int t);
        logic p;
        p = beep_pin_out;
        do begin
            @(posedge clk_in);
        end while (k == 0 ? tick_irq_out !== 1'b1 :
                   k == 1 ? cpu_clk_en_out !== 1'b1 : beep_pin_out === p);
        t = cyc;
    endtask

    // one-cycle halt request
    task automatic do_halt;
        halt_req <= 1'b1;
        @(posedge clk_in);
        halt_req <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    // verdict
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #100000;
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        end_sim;
    end

    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int t0, t1, t2, v, pv;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 3'h0;
        {s_axi_bready_in, s_axi_rready_in} = 2'h3;
        {halt_req, wake_req, mask_req} = 3'h0;
        s_axi_wstrb_in = 4'hF;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 56'h0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(A_CSR, d, r);
        chk("csr reset", 32'h00, d);
        rd(A_BEEP, d, r);
        chk("beep reset", 32'h00, d);
        rd(A_BAD, d, r);
        chk("unmapped rresp", mcc_pkg::RESP_SLVERR, r);
        chk("unmapped rdata", 32'h00, d);
        wr(A_BAD, 32'hFF, r);
        chk("unmapped bresp", mcc_pkg::RESP_SLVERR, r);
        repeat (4) begin
            v = $random(seed) & 32'hFE;
            wr(A_CSR, v, r);
            rd(A_CSR, d, r);
            chk("csr rw", v, d & 32'hFE);
            v = $random(seed) & 32'h03;
            wr(A_BEEP, v, r);
            rd(A_BEEP, d, r);
            chk("beep rw", v, d);
        end
        wr(A_CSR, 32'h02, r);
        rd(A_CSR, d, r);
        wait_hi(0, t0);
        mask_req <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("irq masked", 1'b0, tick_irq_out);
        mask_req <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("irq unmasked", 1'b1, tick_irq_out);
        rd(A_CSR, d, r);
        chk("flag read", 1'b1, d[0]);
        rd(A_CSR, d, r);
        chk("flag cleared", 1'b0, d[0]);
        wait_hi(0, t0);
        pv = 0;
        foreach (TB_DIV[i]) begin
            v = (i + 1) % 4;
            exp_q.push_back(TB_DIV[pv]);
            exp_q.push_back(TB_DIV[v]);
            rd(A_CSR, d, r);
            wr(A_CSR, 32'h02 | (v << 2), r);
            wait_hi(0, t1);
            chk("old period", exp_q.pop_front(), t1 - t0);
            rd(A_CSR, d, r);
            wait_hi(0, t2);
            chk("new period", exp_q.pop_front(), t2 - t1);
            t0 = t2;
            pv = v;
        end
        for (int i = 0; i < 5; i++) begin
            wr(A_CSR, i < 4 ? 32'h10 | (i << 5) : 32'h00, r);
            wait_hi(1, t0);
            wait_hi(1, t1);
            wait_hi(1, t2);
            chk("cpu clock gap", i < 4 ? 2 << i : 1, t2 - t1);
        end
        for (int c = 0; c < 4; c++) begin
            wr(A_BEEP, c, r);
            @(posedge clk_in);
            chk("beep oe", c != 0, beep_oe_out);
            if (c != 0) begin
                wait_hi(2, t0);
                wait_hi(2, t1);
                wait_hi(2, t2);
                chk("beep half period", BEEP_HALF[c], t2 - t1);
            end
        end
        wr(A_CSR, 32'h8E, r);
        @(posedge clk_in);
        chk("clock out oe", 1'b1, clock_out_oe_out);
        rd(A_CSR, d, r);
        wait_hi(0, t0);
        rd(A_CSR, d, r);
        wr(A_BEEP, 32'h01, r);
        do_halt;
        chk("mode active halt", mcc_pkg::PM_ACTIVE_HALT, power_mode_out);
        wr(A_BEEP, 32'h00, r);
        wait_hi(2, t1);
        do @(posedge clk_in); while (power_mode_out !== mcc_pkg::PM_RUN);
        rd(A_BEEP, d, r);
        chk("beep frozen", 32'h01, d);
        wr(A_CSR, 32'h0C, r);
        rd(A_CSR, d, r);
        do_halt;
        chk("mode halt", mcc_pkg::PM_HALT, power_mode_out);
        t0 = cpu_ticks;
        // past the longest tick period
        repeat (300) @(posedge clk_in);
        chk("halt holds", mcc_pkg::PM_HALT, power_mode_out);
        chk("cpu ticks frozen", t0, cpu_ticks);
        wake_req <= 1'b1;
        @(posedge clk_in);
        wake_req <= 1'b0;
        do @(posedge clk_in); while (power_mode_out !== mcc_pkg::PM_RUN);
        rd(A_CSR, d, r);
        chk("csr kept", 32'h0C, d & 32'hFE);
        end_sim;
    end
endmodule
